/* hw/ebac_ctrl.sv */
// Nonvolatile store access controller: I/O register decode, store array and write engine.
// Assumes the CPU issues one access per cycle when valid and honours cpu_stall.
`timescale 1ns/1ps
`default_nettype none

module ebac_ctrl #(
   parameter int STORE_BYTES = 512,
   parameter int ADDR_W      = 9,
   parameter int ATOMIC_CYC  = ebac_pkg::ATOMIC_CYCLES,
   parameter int SPLIT_CYC   = ebac_pkg::SPLIT_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       por_resetn,
   input  wire logic       acc_valid,
   input  wire logic [2:0] acc_kind,
   input  wire logic [7:0] acc_addr,
   input  wire logic [2:0] acc_bit,
   input  wire logic [7:0] acc_wdata,
   output logic      [7:0] acc_rdata,
   output logic            acc_bit_value,
   output logic            acc_rvalid,
   output logic            cpu_stall,
   output logic            write_busy,
   output logic            ready_irq_en
);

   typedef enum logic [1:0] {
      EBAC_IDLE = 2'b01,
      EBAC_BUSY = 2'b10
   } ebac_eng_e;

   localparam logic [ebac_pkg::WCNT_W-1:0] ATOMIC_LOAD = ebac_pkg::WCNT_W'(ATOMIC_CYC);
   localparam logic [ebac_pkg::WCNT_W-1:0] SPLIT_LOAD  = ebac_pkg::WCNT_W'(SPLIT_CYC);
   localparam logic [ebac_pkg::WCNT_W-1:0] WCNT_LAST   = ebac_pkg::WCNT_W'(1);

   logic [7:0] store_mem [STORE_BYTES];

   // Register-side state (system reset)
   logic [7:0]        data_reg,    data_next;
   logic [7:0]        addr_lo_reg, addr_lo_next;
   logic              addr_hi_reg, addr_hi_next;
   logic [1:0]        mode_reg,    mode_next;
   logic              irq_en_reg,  irq_en_next;
   logic [2:0]        mpe_cnt_reg, mpe_cnt_next;
   logic [2:0]        stall_reg,   stall_next;
   logic              done_reg,    done_next;
   logic [7:0]        gp_reg [3];
   logic [7:0]        gp_next [3];
   logic [7:0]        rdata_reg,   rdata_next;
   logic              bitv_reg,    bitv_next;
   logic              rvalid_reg,  rvalid_next;

   // Write engine state (power-on reset only)
   ebac_eng_e                   eng_reg,   eng_next;
   logic [ebac_pkg::WCNT_W-1:0] wcnt_reg,  wcnt_next;
   logic [ADDR_W-1:0]           waddr_reg, waddr_next;
   logic [7:0]                  wdata_reg, wdata_next;
   logic [1:0]                  wmode_reg, wmode_next;

   // Decode
   logic              io_hit;
   logic [5:0]        io_idx;
   logic              is_wr;
   logic              is_rd;
   logic [7:0]        wmask;
   logic [7:0]        wval;
   logic              busy;
   logic              mpe_active;
   logic              rd_start;
   logic              wr_start;
   logic              wr_done;
   logic [ADDR_W-1:0] store_addr;
   logic [7:0]        read_mux;
   logic [7:0]        commit_byte;
   logic [7:0]        mem_at_addr;
   logic [7:0]        mem_at_waddr;

   assign busy         = (eng_reg == EBAC_BUSY);
   assign mpe_active   = (mpe_cnt_reg != 3'h0);
   assign store_addr   = ADDR_W'({addr_hi_reg, addr_lo_reg});
   assign mem_at_addr  = store_mem[store_addr];
   assign mem_at_waddr = store_mem[waddr_reg];
   assign wr_done      = busy && (wcnt_reg == WCNT_LAST);

   always_comb begin
      io_hit = 1'b0;
      io_idx = 6'h00;
      is_wr  = 1'b0;
      is_rd  = 1'b0;
      wmask  = 8'hFF;
      wval   = acc_wdata;
      if (acc_valid) begin
         unique case (acc_kind)
            ebac_pkg::ACC_IN, ebac_pkg::ACC_OUT: begin
               io_hit = (acc_addr <= ebac_pkg::IO_RANGE_END);
               io_idx = acc_addr[5:0];
               is_wr  = (acc_kind == ebac_pkg::ACC_OUT);
               is_rd  = !is_wr;
            end
            ebac_pkg::ACC_LD, ebac_pkg::ACC_ST: begin
               // Extended I/O above 0x5F holds nothing here: reads zero, writes dropped
               io_hit = (acc_addr >= ebac_pkg::DATA_OFFSET) && (acc_addr <= ebac_pkg::DATA_IO_END);
               io_idx = 6'(acc_addr - ebac_pkg::DATA_OFFSET);
               is_wr  = (acc_kind == ebac_pkg::ACC_ST);
               is_rd  = !is_wr;
            end
            ebac_pkg::ACC_SBI, ebac_pkg::ACC_CBI, ebac_pkg::ACC_BTST: begin
               io_hit = (acc_addr <= ebac_pkg::BIT_RANGE_END);
               io_idx = acc_addr[5:0];
               is_wr  = (acc_kind != ebac_pkg::ACC_BTST);
               is_rd  = !is_wr;
               wmask  = 8'(8'h01 << acc_bit);
               wval   = (acc_kind == ebac_pkg::ACC_SBI) ? wmask : ebac_pkg::ZERO_BYTE;
            end
            default: begin
               io_hit = 1'b0;
            end
         endcase
      end
   end

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] m, input logic [7:0] v);
      merge = (old & ~m) | (v & m);
   endfunction

   logic ctrl_wr;
   assign ctrl_wr = io_hit && is_wr && (io_idx == ebac_pkg::IDX_CTRL);

   assign rd_start = ctrl_wr && wmask[ebac_pkg::CTRL_READ_STROBE]
                     && wval[ebac_pkg::CTRL_READ_STROBE] && !busy;
   assign wr_start = ctrl_wr && wmask[ebac_pkg::CTRL_WRITE_STROBE] && wval[ebac_pkg::CTRL_WRITE_STROBE]
                     && mpe_active && !busy && (mode_reg != ebac_pkg::MODE_RESERVED);

   always_comb begin
      read_mux = ebac_pkg::ZERO_BYTE;
      unique case (io_idx)
         ebac_pkg::IDX_STATUS:  read_mux = {7'h00, done_reg};
         ebac_pkg::IDX_GP0:     read_mux = gp_reg[0];
         ebac_pkg::IDX_CTRL:    read_mux = {2'h0, mode_reg, irq_en_reg, mpe_active, busy, 1'b0};
         ebac_pkg::IDX_DATA:    read_mux = data_reg;
         ebac_pkg::IDX_ADDR_LO: read_mux = addr_lo_reg;
         ebac_pkg::IDX_ADDR_HI: read_mux = {7'h00, addr_hi_reg};
         ebac_pkg::IDX_GP1:     read_mux = gp_reg[1];
         ebac_pkg::IDX_GP2:     read_mux = gp_reg[2];
         default:               read_mux = ebac_pkg::ZERO_BYTE;
      endcase
   end

   // Register-side next state
   always_comb begin
      data_next    = data_reg;
      addr_lo_next = addr_lo_reg;
      addr_hi_next = addr_hi_reg;
      mode_next    = mode_reg;
      irq_en_next  = irq_en_reg;
      mpe_cnt_next = mpe_active ? 3'(mpe_cnt_reg - 3'h1) : 3'h0;
      stall_next   = (stall_reg != 3'h0) ? 3'(stall_reg - 3'h1) : 3'h0;
      done_next    = done_reg;
      gp_next      = gp_reg;
      rdata_next   = rdata_reg;
      bitv_next    = bitv_reg;
      rvalid_next  = io_hit && is_rd;
      if (io_hit && is_rd) begin
         rdata_next = read_mux;
         bitv_next  = read_mux[acc_bit];
      end else if (acc_valid && is_rd) begin
         rdata_next = ebac_pkg::ZERO_BYTE;
         bitv_next  = 1'b0;
         rvalid_next = 1'b1;
      end
      if (io_hit && is_wr) begin
         unique case (io_idx)
            ebac_pkg::IDX_STATUS: begin
               if (wmask[ebac_pkg::STATUS_DONE] && wval[ebac_pkg::STATUS_DONE]) begin
                  done_next = 1'b0;
               end
            end
            ebac_pkg::IDX_GP0:  gp_next[0] = merge(gp_reg[0], wmask, wval);
            ebac_pkg::IDX_GP1:  gp_next[1] = merge(gp_reg[1], wmask, wval);
            ebac_pkg::IDX_GP2:  gp_next[2] = merge(gp_reg[2], wmask, wval);
            ebac_pkg::IDX_DATA: data_next  = merge(data_reg, wmask, wval);
            ebac_pkg::IDX_ADDR_LO: begin
               if (!busy) begin
                  addr_lo_next = merge(addr_lo_reg, wmask, wval);
               end
            end
            ebac_pkg::IDX_ADDR_HI: begin
               if (!busy && wmask[ebac_pkg::ADDR_HI_BIT8]) begin
                  addr_hi_next = wval[ebac_pkg::ADDR_HI_BIT8];
               end
            end
            ebac_pkg::IDX_CTRL: begin
               if (!busy) begin
                  if (wmask[ebac_pkg::CTRL_MODE_LO]) begin
                     mode_next[0] = wval[ebac_pkg::CTRL_MODE_LO];
                  end
                  if (wmask[ebac_pkg::CTRL_MODE_HI]) begin
                     mode_next[1] = wval[ebac_pkg::CTRL_MODE_HI];
                  end
               end
               if (wmask[ebac_pkg::CTRL_READY_IE]) begin
                  irq_en_next = wval[ebac_pkg::CTRL_READY_IE];
               end
               if (wmask[ebac_pkg::CTRL_MASTER_EN]) begin
                  mpe_cnt_next = wval[ebac_pkg::CTRL_MASTER_EN] ? ebac_pkg::MASTER_EN_CYCLES : 3'h0;
               end
            end
            default: begin
               data_next = data_reg;
            end
         endcase
      end
      if (rd_start) begin
         data_next  = mem_at_addr;
         stall_next = ebac_pkg::READ_STALL;
      end
      if (wr_start) begin
         stall_next = ebac_pkg::WRITE_STALL;
      end
      if (wr_done) begin
         done_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         data_reg    <= ebac_pkg::ZERO_BYTE;
         addr_lo_reg <= ebac_pkg::ZERO_BYTE;
         addr_hi_reg <= 1'b0;
         mode_reg    <= ebac_pkg::RESET_MODE;
         irq_en_reg  <= 1'b0;
         mpe_cnt_reg <= 3'h0;
         stall_reg   <= 3'h0;
         done_reg    <= 1'b0;
         gp_reg      <= '{default: ebac_pkg::ZERO_BYTE};
         rdata_reg   <= ebac_pkg::ZERO_BYTE;
         bitv_reg    <= 1'b0;
         rvalid_reg  <= 1'b0;
      end else begin
         data_reg    <= data_next;
         addr_lo_reg <= addr_lo_next;
         addr_hi_reg <= addr_hi_next;
         mode_reg    <= mode_next;
         irq_en_reg  <= irq_en_next;
         mpe_cnt_reg <= mpe_cnt_next;
         stall_reg   <= stall_next;
         done_reg    <= done_next;
         gp_reg      <= gp_next;
         rdata_reg   <= rdata_next;
         bitv_reg    <= bitv_next;
         rvalid_reg  <= rvalid_next;
      end
   end

   // Write engine next state
   always_comb begin
      eng_next   = eng_reg;
      wcnt_next  = wcnt_reg;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      wmode_next = wmode_reg;
      unique case (eng_reg)
         EBAC_IDLE: begin
            if (wr_start) begin
               eng_next   = EBAC_BUSY;
               waddr_next = store_addr;
               wdata_next = data_reg;
               wmode_next = mode_reg;
               wcnt_next  = (mode_reg == ebac_pkg::MODE_ATOMIC) ? ATOMIC_LOAD : SPLIT_LOAD;
            end
         end
         EBAC_BUSY: begin
            wcnt_next = ebac_pkg::WCNT_W'(wcnt_reg - WCNT_LAST);
            if (wr_done) begin
               eng_next = EBAC_IDLE;
            end
         end
         default: begin
            eng_next = EBAC_IDLE;
         end
      endcase
   end

   // System reset does not reach the engine, so an accepted write completes unless power-on reset arrives
   always_ff @(posedge clk or negedge por_resetn) begin
      if (!por_resetn) begin
         eng_reg   <= EBAC_IDLE;
         wcnt_reg  <= '0;
         waddr_reg <= '0;
         wdata_reg <= ebac_pkg::ZERO_BYTE;
         wmode_reg <= ebac_pkg::RESET_MODE;
      end else begin
         eng_reg   <= eng_next;
         wcnt_reg  <= wcnt_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         wmode_reg <= wmode_next;
      end
   end

   always_comb begin
      unique case (wmode_reg)
         ebac_pkg::MODE_ERASE: commit_byte = ebac_pkg::ERASED_BYTE;
         ebac_pkg::MODE_WRITE: commit_byte = mem_at_waddr & wdata_reg;
         default:              commit_byte = wdata_reg;
      endcase
   end

   always_ff @(posedge clk) begin
      if (wr_done) begin
         store_mem[waddr_reg] <= commit_byte;
      end
   end

   assign acc_rdata     = rdata_reg;
   assign acc_bit_value = bitv_reg;
   assign acc_rvalid    = rvalid_reg;
   assign cpu_stall     = (stall_reg != 3'h0);
   assign write_busy    = busy;
   assign ready_irq_en  = irq_en_reg;

   // Assertions
   property p_read_stall;
      @(posedge clk) disable iff (!resetn) rd_start |=> cpu_stall [*4] ##1 !cpu_stall;
   endproperty
   a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles");

   property p_write_stall;
      @(posedge clk) disable iff (!resetn) wr_start |=> cpu_stall [*2] ##1 !cpu_stall;
   endproperty
   a_write_stall: assert property (p_write_stall) else $error("write stall not two cycles");

   property p_mpe_timeout;
      @(posedge clk) disable iff (!resetn)
         (ctrl_wr && wmask[ebac_pkg::CTRL_MASTER_EN] && wval[ebac_pkg::CTRL_MASTER_EN])
         ##1 !ctrl_wr [*4] |=> !mpe_active;
   endproperty
   a_mpe_timeout: assert property (p_mpe_timeout) else $error("master enable did not time out");

   property p_start_needs_mpe;
      @(posedge clk) disable iff (!resetn || !por_resetn) $rose(busy) |-> $past(mpe_active);
   endproperty
   a_start_needs_mpe: assert property (p_start_needs_mpe) else $error("write began without master enable");

   property p_addr_frozen;
      @(posedge clk) disable iff (!resetn || !por_resetn) busy |=> $stable({addr_hi_reg, addr_lo_reg});
   endproperty
   a_addr_frozen: assert property (p_addr_frozen) else $error("address changed during write");

   property p_hi_reserved;
      @(posedge clk) disable iff (!resetn)
         (io_hit && is_rd && io_idx == ebac_pkg::IDX_ADDR_HI) |=> (acc_rdata[7:1] == 7'h00);
   endproperty
   a_hi_reserved: assert property (p_hi_reserved) else $error("reserved address bits read nonzero");

   property p_done_sets;
      @(posedge clk) disable iff (!resetn || !por_resetn) wr_done |=> done_reg && !busy;
   endproperty
   a_done_sets: assert property (p_done_sets) else $error("completion not flagged");

   property p_w1c;
      @(posedge clk) disable iff (!resetn)
         (io_hit && is_wr && io_idx == ebac_pkg::IDX_STATUS && wmask[0] && wval[0] && !wr_done) |=> !done_reg;
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared by writing one");

   property p_read_load;
      @(posedge clk) disable iff (!resetn) rd_start |=> (data_reg == $past(mem_at_addr));
   endproperty
   a_read_load: assert property (p_read_load) else $error("read strobe did not load data");

   property p_no_read_busy;
      @(posedge clk) disable iff (!resetn || !por_resetn) (busy && ctrl_wr && !mpe_active) |=> $stable(data_reg);
   endproperty
   a_no_read_busy: assert property (p_no_read_busy) else $error("read honoured during write");

   c_write: cover property (@(posedge clk) disable iff (!resetn) wr_start ##1 busy);
   c_read:  cover property (@(posedge clk) disable iff (!resetn) rd_start);
   c_done:  cover property (@(posedge clk) disable iff (!resetn) wr_done);

endmodule

`default_nettype wire

/* hw/ebac_pkg.sv */
// Constants for the byte-wide nonvolatile store access controller.
// Assumes a single 100 MHz CPU clock; all register locations are I/O indices 0x00-0x3F.
//
// Functional notes
// - Separate nonvolatile store of up to 512 bytes, one byte per access.
// - Store address, data and control registers sit in the I/O register space.
// - Block times each write itself and shows when the next byte may go.
// - A store read stalls the CPU for four clock cycles.
// - Starting a store write stalls the CPU for two clock cycles.
// - Writes start only through the protected enable-then-strobe sequence.
// - A write in progress completes even if system reset arrives.
// - Single-bit set, clear and test act on I/O registers 0x00-0x1F.
// - Direct I/O uses 0x00-0x3F; load/store sees them at address plus 0x20.
// - Extended I/O 0x60-0xFF reachable only by load and store. No extended registers exist here: loads read zero, stores are dropped.
// - Some status flags clear when software writes one to them.
// - Bit set and clear touch only the addressed bit.
// - Three general purpose storage registers; low-range ones are bit-accessible.
// - 9-bit store address: low byte at 0x21, bit 8 at bit 0 of 0x22.
// - Upper bits of the high address register always read zero.
// - Store bytes are mapped linearly from zero to capacity minus one.
// - Address is undefined after reset; software loads it before any access. System reset here clears it to zero.
// - Master enable self-clears after four cycles; strobe starts write only while set.
// - Write strobe clears at completion; while set, reads, address and mode changes ignored.
// - Mode field: 00 erase+write, 01 erase only, 10 write only, 11 reserved.
// - Read strobe loads the addressed byte into the data register at once.
`default_nettype none

package ebac_pkg;

   // Access kinds issued by the CPU core
   localparam logic [2:0] ACC_IN   = 3'h0;
   localparam logic [2:0] ACC_OUT  = 3'h1;
   localparam logic [2:0] ACC_LD   = 3'h2;
   localparam logic [2:0] ACC_ST   = 3'h3;
   localparam logic [2:0] ACC_SBI  = 3'h4;
   localparam logic [2:0] ACC_CBI  = 3'h5;
   localparam logic [2:0] ACC_BTST = 3'h6;

   // Address ranges
   localparam logic [7:0] BIT_RANGE_END = 8'h1F;
   localparam logic [7:0] IO_RANGE_END  = 8'h3F;
   localparam logic [7:0] DATA_OFFSET   = 8'h20;
   localparam logic [7:0] DATA_IO_END   = 8'h5F;

   // I/O register indices
   localparam logic [5:0] IDX_STATUS  = 6'h1C;
   localparam logic [5:0] IDX_GP0     = 6'h1E;
   localparam logic [5:0] IDX_CTRL    = 6'h1F;
   localparam logic [5:0] IDX_DATA    = 6'h20;
   localparam logic [5:0] IDX_ADDR_LO = 6'h21;
   localparam logic [5:0] IDX_ADDR_HI = 6'h22;
   localparam logic [5:0] IDX_GP1     = 6'h2A;
   localparam logic [5:0] IDX_GP2     = 6'h2B;

   // Control, status and address register fields
   localparam int CTRL_READ_STROBE  = 0;
   localparam int CTRL_WRITE_STROBE = 1;
   localparam int CTRL_MASTER_EN    = 2;
   localparam int CTRL_READY_IE     = 3;
   localparam int CTRL_MODE_LO      = 4;
   localparam int CTRL_MODE_HI      = 5;
   localparam int STATUS_DONE       = 0;
   localparam int ADDR_HI_BIT8      = 0;

   // Programming modes
   localparam logic [1:0] MODE_ATOMIC   = 2'h0;
   localparam logic [1:0] MODE_ERASE    = 2'h1;
   localparam logic [1:0] MODE_WRITE    = 2'h2;
   localparam logic [1:0] MODE_RESERVED = 2'h3;

   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] ZERO_BYTE   = 8'h00;
   localparam logic [1:0] RESET_MODE  = 2'h0;

   // Timing
   localparam logic [2:0] MASTER_EN_CYCLES = 3'h4;
   localparam logic [2:0] READ_STALL       = 3'h4;
   localparam logic [2:0] WRITE_STALL      = 3'h2;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int ATOMIC_TIME_US = 3400;
   localparam int SPLIT_TIME_US  = 1800;
   localparam int ATOMIC_CYCLES  = ATOMIC_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int SPLIT_CYCLES   = SPLIT_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int WCNT_W         = 20;

endpackage

`default_nettype wire

/* verification/ebac_cpu_model.sv */
// CPU core model driving the access port of ebac_ctrl.
// Assumes one access per call, taken at one edge, answer read one cycle later.
`timescale 1ns/1ps
`default_nettype none
module ebac_cpu_model (
   input  wire logic       clk,
   input  wire logic       cpu_stall,
   input  wire logic [7:0] acc_rdata,
   input  wire logic       acc_bit_value,
   output logic            acc_valid,
   output logic      [2:0] acc_kind,
   output logic      [7:0] acc_addr,
   output logic      [2:0] acc_bit,
   output logic      [7:0] acc_wdata
);
   logic [7:0] rd;
   logic       rbit;
   initial begin
      acc_valid = 1'b0;
      acc_kind  = 3'h7;
      acc_addr  = 8'h00;
      acc_bit   = 3'h0;
      acc_wdata = 8'h00;
   end
   task automatic acc(input logic [2:0] k, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
      @(posedge clk);
      #1;
      while (cpu_stall === 1'b1) begin
         @(posedge clk);
         #1;
      end
      acc_valid = 1'b1;
      acc_kind  = k;
      acc_addr  = a;
      acc_bit   = b;
      acc_wdata = d;
      @(posedge clk);
      #1;
      rd        = acc_rdata;
      rbit      = acc_bit_value;
      acc_valid = 1'b0;
      acc_addr  = ~a;
      acc_bit   = ~b;
      acc_wdata = ~d;
   endtask
endmodule
`default_nettype wire

/* verification/ebac_ctrl_tb_top.sv */
// Self-checking bench for ebac_ctrl driven through the CPU core model.
// Assumes short write times through ATOMIC_CYC and SPLIT_CYC.
`timescale 1ns/1ps
`default_nettype none
module ebac_ctrl_tb_top;
   logic       clk;
   logic       resetn;
   logic       por_resetn;
   logic       acc_valid;
   logic [2:0] acc_kind;
   logic [7:0] acc_addr;
   logic [2:0] acc_bit;
   logic [7:0] acc_wdata;
   logic [7:0] acc_rdata;
   logic       acc_bit_value;
   logic       acc_rvalid;
   logic       cpu_stall;
   logic       write_busy;
   logic       ready_irq_en;
   logic [7:0] sh [512];
   logic [7:0] v;
   logic [7:0] d;
   logic [8:0] a;
   int         n_fail;
   int         num_checks;
   int         n_stall;
   integer     seed;

   ebac_ctrl #(.ATOMIC_CYC(20), .SPLIT_CYC(10)) dut_u (.clk(clk), .resetn(resetn), .por_resetn(por_resetn),
      .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr), .acc_bit(acc_bit),
      .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_bit_value(acc_bit_value), .acc_rvalid(acc_rvalid),
      .cpu_stall(cpu_stall), .write_busy(write_busy), .ready_irq_en(ready_irq_en));
   ebac_cpu_model cpu_u (.clk(clk), .cpu_stall(cpu_stall), .acc_rdata(acc_rdata), .acc_bit_value(acc_bit_value),
      .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (cpu_stall === 1'b1) begin
         n_stall++;
      end
   end

   function automatic logic [7:0] f_exp(input logic [1:0] m, input logic [7:0] old, input logic [7:0] nd);
      case (m)
         ebac_pkg::MODE_ATOMIC: return nd;
         ebac_pkg::MODE_ERASE:  return ebac_pkg::ERASED_BYTE;
         ebac_pkg::MODE_WRITE:  return old & nd;
         default:               return old;
      endcase
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic op(input logic [2:0] k, input logic [7:0] ad, input logic [2:0] b, input logic [7:0] wd);
      cpu_u.acc(k, ad, b, wd);
      v = cpu_u.rd;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
      op(ebac_pkg::ACC_OUT, ad, 3'h0, wd);
   endtask
   task automatic rd(input logic [7:0] ad);
      op(ebac_pkg::ACC_IN, ad, 3'h0, 8'h00);
   endtask
   task automatic set_addr(input logic [8:0] ad);
      wr(8'h21, ad[7:0]);
      wr(8'h22, {7'h00, ad[8]});
   endtask
   task automatic wait_done;
      int k;
      k = 0;
      rd(8'h1F);
      while (v[1] !== 1'b0 && k < 200) begin
         rd(8'h1F);
         k++;
      end
      chk("write_timeout", 8'(k < 200), 8'h01);
   endtask
   task automatic do_write(input logic [8:0] ad, input logic [7:0] wd, input logic [1:0] m);
      set_addr(ad);
      wr(8'h20, wd);
      wr(8'h1F, {2'b00, m, 4'b0100});
      n_stall = 0;
      op(ebac_pkg::ACC_SBI, 8'h1F, 3'h1, 8'h00);
      chk("write_busy", {7'h00, write_busy}, 8'(m != 2'h3));
      if (m != 2'h3) begin
         wait_done();
         chk("write_stall", 8'(n_stall), 8'h02);
         rd(8'h1C);
         chk("done_flag", v, 8'h01);
         op(ebac_pkg::ACC_SBI, 8'h1C, 3'h3, 8'h00);
         op(ebac_pkg::ACC_BTST, 8'h1C, 3'h0, 8'h00);
         chk("done_kept", {7'h00, cpu_u.rbit}, 8'h01);
         op(ebac_pkg::ACC_SBI, 8'h1C, 3'h0, 8'h00);
         rd(8'h1C);
         chk("done_clr", v, 8'h00);
         sh[ad] = f_exp(m, sh[ad], wd);
      end
   endtask
   task automatic do_read(input logic [8:0] ad);
      set_addr(ad);
      n_stall = 0;
      op(ebac_pkg::ACC_SBI, 8'h1F, 3'h0, 8'h00);
      rd(8'h20);
      chk("read_valid", {7'h00, acc_rvalid}, 8'h01);
      chk("read_stall", 8'(n_stall), 8'h04);
      chk("store_byte", v, sh[ad]);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #100000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      seed = 32'h674f_0cc2;
      n_fail = 0;
      num_checks = 0;
      n_stall = 0;
      resetn = 1'b0;
      por_resetn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      resetn = 1'b1;
      por_resetn = 1'b1;
      rd(8'h1F);
      chk("ctrl_reset", v, 8'h00);
      wr(8'h22, 8'hFF);
      rd(8'h22);
      chk("addr_hi", v, 8'h01);
      op(ebac_pkg::ACC_SBI, 8'h1F, 3'h1, 8'h00);
      chk("no_enable", {7'h00, write_busy}, 8'h00);
      wr(8'h1F, 8'h0C);
      chk("irq_en", {7'h00, ready_irq_en}, 8'h01);
      repeat (6) @(posedge clk);
      rd(8'h1F);
      chk("enable_expired", v, 8'h08);
      op(ebac_pkg::ACC_SBI, 8'h1F, 3'h1, 8'h00);
      chk("late_strobe", {7'h00, write_busy}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         a = 9'($random(seed));
         if (i == 0) begin
            a = 9'h1FF;
         end
         foreach (sh[j]) begin
            if (j == 0) begin
               d = 8'($random(seed));
            end
         end
         do_write(a, d, 2'h0);
         do_read(a);
         do_write(a, 8'($random(seed)), 2'h2);
         do_read(a);
         do_write(a, 8'h00, 2'h3);
         do_write(a, 8'h00, 2'h1);
         do_read(a);
      end
      set_addr(9'h055);
      wr(8'h20, 8'hA5);
      wr(8'h1F, 8'h04);
      op(ebac_pkg::ACC_SBI, 8'h1F, 3'h1, 8'h00);
      wr(8'h21, 8'hAA);
      wr(8'h1F, 8'h20);
      n_stall = 0;
      op(ebac_pkg::ACC_SBI, 8'h1F, 3'h0, 8'h00);
      rd(8'h21);
      chk("addr_locked", v, 8'h55);
      chk("read_refused", 8'(n_stall), 8'h00);
      rd(8'h1F);
      chk("mode_locked", v, 8'h02);
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      resetn = 1'b1;
      chk("busy_thru_reset", {7'h00, write_busy}, 8'h01);
      wait_done();
      sh[9'h055] = 8'hA5;
      do_read(9'h055);
      d = 8'($random(seed));
      op(ebac_pkg::ACC_ST, 8'h3E, 3'h0, d);
      op(ebac_pkg::ACC_SBI, 8'h1E, 3'h6, 8'h00);
      op(ebac_pkg::ACC_CBI, 8'h1E, 3'h1, 8'h00);
      rd(8'h1E);
      chk("gp0", v, (d | 8'h40) & 8'hFD);
      op(ebac_pkg::ACC_ST, 8'h4A, 3'h0, d);
      op(ebac_pkg::ACC_SBI, 8'h2A, 3'h0, 8'h00);
      op(ebac_pkg::ACC_LD, 8'h4A, 3'h0, 8'h00);
      chk("gp1", v, d);
      op(ebac_pkg::ACC_LD, 8'h41, 3'h0, 8'h00);
      chk("ld_addr_lo", v, 8'h55);
      op(ebac_pkg::ACC_LD, 8'h60, 3'h0, 8'h00);
      chk("ext_ld", v, 8'h00);
      rd(8'h40);
      chk("in_range", v, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
